// >>> shp_host_port.sv
// sram style host port: pins, halfword pairing, queues, irq, straps
// assumes host strobes are asynchronous and held several mclk cycles
`timescale 1ns/1ns
`default_nettype none
module shp_host_port (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // host bus pins
  input wire logic [6:0] hostAddr,
  input wire logic [15:0] hostDataIn,
  output logic [15:0] hostDataOut,
  output logic hostDataOe,
  input wire logic host_select_n,
  input wire logic host_read_strobe_n,
  input wire logic host_write_strobe_n,
  input wire logic queueSelect,
  // configuration
  input wire logic bigEndian,
  input wire logic irqActiveHigh,
  input wire logic irqOpenDrain,
  input wire logic [7:0] irqEnable,
  input wire logic [15:0] irqGapCycles,
  input wire logic [7:0] irqSources,
  input wire logic lowPowerReq,
  // transmit queue word out
  output logic txWordValid,
  output logic [31:0] txWord,
  // receive queue word in
  input wire logic [31:0] rxWord,
  output logic rxWordTaken,
  // interrupt pin
  output logic irqOut,
  output logic irqOe,
  // straps, link and power state
  input wire logic speedStrap,
  input wire logic crossover_auto_strap,
  input wire logic reverseDetected,
  input wire logic reverseManual,
  output logic linkSpeed100,
  output logic linkDuplexFull,
  output logic linkAutoNeg,
  output logic crossoverAuto,
  output logic pairSwap,
  output logic lowPower,
  output logic writesArmed
);
  localparam int NS = 7 + 16 + 4 + 2;
  logic [NS-1:0] syncIn;
  logic [NS-1:0] syncOut;
  logic [6:0] sAddr;
  logic [15:0] sData;
  logic sSel, sRdOn, sWrOn, sQsel, sSpeed, sXover;
  logic rdAct, wrAct, wrPrev_q, rdPrev_q;
  logic wrStart, rdStart, rdEnd, isQueue, isTx;
  logic [3:0] regIdx;
  logic [31:0] regs_q [shp_pkg::NREG];
  logic [15:0] lowHalf_q;
  logic [31:0] rxHold_q;
  logic strapsTaken_q;
  logic [1:0] strapWait_q;
  logic [15:0] gapCnt_q;
  logic irqLevel_q;
  logic irqPend;

  // select and strobes inverted so a cleared synchroniser reads as idle
  assign syncIn = {hostAddr, hostDataIn, ~host_select_n,
                   ~host_read_strobe_n, ~host_write_strobe_n, queueSelect,
                   speedStrap, crossover_auto_strap};
  shp_sync #(.W(NS)) uSync (
    .mclk(mclk),
    .rst_b(rst_b),
    .async(syncIn),
    .synced(syncOut)
  );
  assign {sAddr, sData, sSel, sRdOn, sWrOn, sQsel, sSpeed, sXover} = syncOut;

  // byte order swap within a halfword
  function automatic logic [15:0] order(input logic [15:0] v,
                                        input logic big);
    order = big ? {v[7:0], v[15:8]} : v;
  endfunction : order

  assign rdAct = sSel && sRdOn; // RULE_03 RULE_05
  assign wrAct = sSel && sWrOn; // RULE_04 RULE_05
  assign wrStart = wrAct && !wrPrev_q;
  assign rdStart = rdAct && !rdPrev_q;
  assign rdEnd = !rdAct && rdPrev_q;
  // queue select overrides the upper address bits
  assign isQueue = sQsel || (sAddr <= shp_pkg::QUEUE_LAST); // RULE_07 RULE_02
  // under queue select the tx bit is an ignored upper bit: direction decides
  assign isTx = !sQsel && sAddr[shp_pkg::QUEUE_TX_BIT]; // RULE_07
  assign regIdx = sAddr[4:1];

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wrPrev_q <= 1'b0;
      rdPrev_q <= 1'b0;
    end else begin
      wrPrev_q <= wrAct;
      rdPrev_q <= rdAct;
    end
  end

  // power state: host write wakes, read arms writes
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      lowPower <= 1'b0;
      writesArmed <= 1'b0;
    end else begin
      if (wrStart) begin
        lowPower <= 1'b0; // RULE_06
      end else if (lowPowerReq && !lowPower) begin
        lowPower <= 1'b1;
      end
      if (lowPowerReq && !lowPower) begin
        writesArmed <= 1'b0; // RULE_15
      end else if (rdStart && !lowPower) begin
        writesArmed <= 1'b1; // RULE_15
      end
    end
  end

  // writes: pair halves into words, A[0]=1 is the upper half
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      lowHalf_q <= 16'h0000;
      txWordValid <= 1'b0;
      txWord <= 32'h0000_0000;
      for (int i = 0; i < shp_pkg::NREG; i++) begin
        regs_q[i] <= shp_pkg::REG_RESET;
      end
    end else begin
      txWordValid <= 1'b0;
      if (wrStart && writesArmed && !lowPower) begin
        if (!sAddr[0]) begin
          lowHalf_q <= order(sData, bigEndian); // RULE_08 RULE_01
        end else if (isQueue && (isTx || sQsel)) begin // RULE_07
          txWord <= {order(sData, bigEndian), lowHalf_q}; // RULE_01
          txWordValid <= 1'b1;
        end else if (!isQueue) begin
          regs_q[regIdx] <= {order(sData, bigEndian), lowHalf_q}; // RULE_02
        end
      end
    end
  end

  // reads: low half fetches the word, upper half returns held half
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rxHold_q <= 32'h0000_0000;
      rxWordTaken <= 1'b0;
      hostDataOut <= 16'h0000;
      hostDataOe <= 1'b0;
    end else begin
      rxWordTaken <= 1'b0;
      hostDataOe <= rdAct; // RULE_14
      if (rdStart) begin
        if (!sAddr[0]) begin
          if (isQueue) begin
            rxHold_q <= rxWord;
            hostDataOut <= order(rxWord[15:0], bigEndian); // RULE_01
          end else begin
            rxHold_q <= regs_q[regIdx];
            hostDataOut <= order(regs_q[regIdx][15:0], bigEndian);
          end
        end else begin
          hostDataOut <= order(rxHold_q[31:16], bigEndian); // RULE_08
        end
      end
      if (rdEnd && isQueue && !isTx && sAddr[0]) begin
        rxWordTaken <= 1'b1; // RULE_01
      end
    end
  end

  // interrupt with deassertion gap
  assign irqPend = |(irqSources & irqEnable); // RULE_09
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      irqLevel_q <= 1'b0;
      gapCnt_q <= shp_pkg::GAP_RESET;
    end else begin
      if (irqLevel_q && !irqPend) begin
        irqLevel_q <= 1'b0;
        gapCnt_q <= irqGapCycles; // RULE_10
      end else if (gapCnt_q != 16'h0000) begin
        gapCnt_q <= gapCnt_q - 16'h0001; // RULE_10
      end else if (irqPend) begin
        irqLevel_q <= 1'b1;
      end
    end
  end
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      irqOut <= 1'b0;
      irqOe <= 1'b0;
    end else begin
      // open drain drives only while the pin level is low
      irqOut <= irqLevel_q ~^ irqActiveHigh; // RULE_09
      irqOe <= irqOpenDrain ? !(irqLevel_q ~^ irqActiveHigh) : 1'b1; // RULE_09
    end
  end

  // straps captured once, after the synchroniser has refilled
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      strapsTaken_q <= 1'b0;
      strapWait_q <= 2'h0;
      linkSpeed100 <= 1'b0;
      linkDuplexFull <= 1'b0;
      linkAutoNeg <= 1'b0;
      crossoverAuto <= 1'b0;
    end else if (!strapsTaken_q) begin
      if (strapWait_q != 2'(shp_pkg::SYNC_STAGES)) begin
        strapWait_q <= strapWait_q + 2'h1;
      end else begin
        strapsTaken_q <= 1'b1;
        linkSpeed100 <= sSpeed; // RULE_11
        linkDuplexFull <= shp_pkg::DUPLEX_HALF; // RULE_11
        linkAutoNeg <= (sSpeed == shp_pkg::SPEED_100); // RULE_11
        crossoverAuto <= sXover; // RULE_12
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pairSwap <= 1'b0;
    end else begin
      pairSwap <= (crossoverAuto && reverseDetected) || reverseManual; // RULE_13
    end
  end

  a_drive_only_read: assert property (@(posedge mclk) disable iff (!rst_b)
    hostDataOe |-> $past(rdAct)) else $error("data driven outside read"); // RULE_14
  a_write_wakes: assert property (@(posedge mclk) disable iff (!rst_b)
    wrStart |=> !lowPower) else $error("write did not wake"); // RULE_06
  a_read_needs_sel: assert property (@(posedge mclk) disable iff (!rst_b)
    (!sSel && hostDataOe) |-> $past(sSel)) else $error("read without select"); // RULE_05
  a_strap_held: assert property (@(posedge mclk) disable iff (!rst_b)
    strapsTaken_q |=> $stable(linkSpeed100)) else $error("speed changed"); // RULE_11
  a_autoneg_tied: assert property (@(posedge mclk) disable iff (!rst_b)
    strapsTaken_q |-> linkAutoNeg == linkSpeed100) else $error("autoneg bad"); // RULE_11
  a_gap_blocks: assert property (@(posedge mclk) disable iff (!rst_b)
    (gapCnt_q != 16'h0000) |=> !$rose(irqLevel_q)) else $error("gap broken"); // RULE_10
  a_tx_pairs: assert property (@(posedge mclk) disable iff (!rst_b)
    txWordValid |-> $past(sAddr[0])) else $error("tx on low half"); // RULE_01
  a_swap_cause: assert property (@(posedge mclk) disable iff (!rst_b)
    pairSwap |-> $past(reverseManual || reverseDetected)) else $error("swap"); // RULE_13
  a_unarmed_write: assert property (@(posedge mclk) disable iff (!rst_b)
    txWordValid |-> $past(writesArmed)) else $error("write before read"); // RULE_15
endmodule : shp_host_port
`default_nettype wire

// >>> shp_pkg.sv
// constants of the sram style host port; its pin synchroniser uses none of them
// assumes one 250 MHz clock mclk and an active-low async reset rst_b
// Notes on behaviour
// RULE_01: 16-bit host halves pair into 32-bit words
// RULE_02: 7-bit halfword address selects register or queue
// RULE_03: only low read strobe means read
// RULE_04: write data captured only on low write strobe
// RULE_05: strobes act only while select is low
// RULE_06: select plus write strobe leaves low power
// RULE_07: queue select forces queue access, ignores upper address
// RULE_08: byte order selectable big or little endian
// RULE_09: interrupt polarity, sources, open-drain programmable
// RULE_10: programmable gap before interrupt reasserts
// RULE_11: speed strap latched at reset release
// RULE_12: crossover strap high enables auto crossover
// RULE_13: reversed cable swaps pair directions
// RULE_14: drive data only during select and read
// RULE_15: host reads once before writes take effect
package shp_pkg;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 16;
  localparam int WORD_W = 32;
  localparam int SRC_W = 8;
  localparam int NREG = 16;
  // halfword address of first queue port; registers sit above QUEUE_LAST
  localparam logic [6:0] QUEUE_BASE = 7'h00;
  localparam logic [6:0] QUEUE_LAST = 7'h0f;
  // within queue window: bit 2 set selects transmit, clear selects receive
  localparam int QUEUE_TX_BIT = 2;
  localparam int REG_BASE_IDX = 16;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  localparam logic [15:0] GAP_RESET = 16'h0000;
  localparam int SYNC_STAGES = 2;
  // strap settings
  localparam logic SPEED_100 = 1'b1;
  localparam logic DUPLEX_HALF = 1'b0;
endpackage : shp_pkg

// >>> shp_sync.sv
// two flip-flop synchroniser for a bus of pin levels
// assumes inputs are asynchronous to mclk
`timescale 1ns/1ns
`default_nettype none
module shp_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // levels
  input wire logic [W-1:0] async,
  output logic [W-1:0] synced
);
  logic [W-1:0] meta_q;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= '0;
      synced <= '0;
    end else begin
      meta_q <= async;
      synced <= meta_q;
    end
  end
endmodule : shp_sync
`default_nettype wire

// >>> shp_host_model.sv
// host processor model: drives the sram style pins, resolves data wire
// assumes mclk from the bench and a device that drives only under oe
`timescale 1ns/1ns
`default_nettype none
module shp_host_model (
  // clock
  input wire logic mclk,
  // device data side
  input wire logic [15:0] hostDataOut,
  input wire logic hostDataOe,
  // host pins
  output logic [6:0] hostAddr,
  output logic [15:0] hostDataIn,
  output logic host_select_n,
  output logic host_read_strobe_n,
  output logic host_write_strobe_n
);
  logic drive = 1'b0;
  logic [15:0] drvData = 16'h0000;
  logic [15:0] lastData = 16'h0000;
  initial begin
    hostAddr = 7'h00;
    host_select_n = 1'b1;
    host_read_strobe_n = 1'b1;
    host_write_strobe_n = 1'b1;
  end
  // released wire shows the inverse of its last driven level
  always_comb begin
    if (hostDataOe === 1'b1) hostDataIn = hostDataOut;
    else if (drive) hostDataIn = drvData;
    else hostDataIn = ~lastData;
  end
  always @(posedge mclk) begin
    if (drive || hostDataOe === 1'b1) lastData <= hostDataIn;
  end
  // one access: strobe held six cycles, then a five cycle gap
  task automatic access(input logic [6:0] a, input logic sel,
    input logic wr, input logic [15:0] d, output logic [15:0] q,
    output logic oe);
    @(posedge mclk);
    hostAddr <= a;
    drive <= wr;
    drvData <= d;
    host_select_n <= ~sel;
    host_read_strobe_n <= wr;
    host_write_strobe_n <= ~wr;
    repeat (6) @(posedge mclk);
    q = hostDataIn;
    oe = hostDataOe;
    host_select_n <= 1'b1;
    host_read_strobe_n <= 1'b1;
    host_write_strobe_n <= 1'b1;
    drive <= 1'b0;
    repeat (5) @(posedge mclk);
  endtask : access
endmodule : shp_host_model
`default_nettype wire

// >>> shp_host_port_bench.sv
// bench for the host port: pin accesses, straps, power, interrupt
// assumes the host model file alongside
`timescale 1ns/1ns
`default_nettype none
module shp_host_port_bench;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic queueSelect = 0, bigEndian = 0, irqActiveHigh = 1;
  logic irqOpenDrain = 0, lowPowerReq = 0, speedStrap = 0;
  logic crossover_auto_strap = 0, reverseDetected = 0, reverseManual = 0;
  logic [7:0] irqEnable = 8'h01, irqSources = 8'h00;
  logic [15:0] irqGapCycles = 16'h0040;
  logic [31:0] rxWord = 32'h8765_4321, txWord, txSeen = 0;
  logic [15:0] hostDataOut, hostDataIn, rdQ;
  logic [6:0] hostAddr;
  logic hostDataOe, host_select_n, host_read_strobe_n, host_write_strobe_n;
  logic txWordValid, rxWordTaken, irqOut, irqOe, linkSpeed100, rdOe;
  logic linkDuplexFull, linkAutoNeg, crossoverAuto, pairSwap, lowPower;
  logic writesArmed;
  int txCount = 0, rxCount = 0, mismatches = 0, n_tests = 0;
  always #2 mclk = ~mclk;
  shp_host_port shp_host_port_inst (.mclk(mclk), .rst_b(rst_b),
    .hostAddr(hostAddr), .hostDataIn(hostDataIn),
    .hostDataOut(hostDataOut), .hostDataOe(hostDataOe),
    .host_select_n(host_select_n), .host_read_strobe_n(host_read_strobe_n),
    .host_write_strobe_n(host_write_strobe_n), .queueSelect(queueSelect),
    .bigEndian(bigEndian), .irqActiveHigh(irqActiveHigh),
    .irqOpenDrain(irqOpenDrain), .irqEnable(irqEnable),
    .irqGapCycles(irqGapCycles), .irqSources(irqSources),
    .lowPowerReq(lowPowerReq), .txWordValid(txWordValid), .txWord(txWord),
    .rxWord(rxWord), .rxWordTaken(rxWordTaken), .irqOut(irqOut),
    .irqOe(irqOe), .speedStrap(speedStrap),
    .crossover_auto_strap(crossover_auto_strap),
    .reverseDetected(reverseDetected), .reverseManual(reverseManual),
    .linkSpeed100(linkSpeed100), .linkDuplexFull(linkDuplexFull),
    .linkAutoNeg(linkAutoNeg), .crossoverAuto(crossoverAuto),
    .pairSwap(pairSwap), .lowPower(lowPower), .writesArmed(writesArmed));
  shp_host_model shp_host_model_inst (.mclk(mclk),
    .hostDataOut(hostDataOut), .hostDataOe(hostDataOe),
    .hostAddr(hostAddr), .hostDataIn(hostDataIn),
    .host_select_n(host_select_n), .host_read_strobe_n(host_read_strobe_n),
    .host_write_strobe_n(host_write_strobe_n));
  always @(posedge mclk) begin
    if (txWordValid === 1'b1) begin
      txCount <= txCount + 1;
      txSeen <= txWord;
    end
    if (rxWordTaken === 1'b1) rxCount <= rxCount + 1;
  end
  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : complete_run
  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
  endtask : idle
  task automatic acc(input logic [6:0] a, input logic sel, input logic wr,
    input logic [15:0] d);
    shp_host_model_inst.access(a, sel, wr, d, rdQ, rdOe);
  endtask : acc
  initial begin
    idle(20000);
    mismatches++;
    complete_run();
  end
  initial begin
    for (int s = 0; s < 2; s++) begin
      rst_b <= 1'b0;
      speedStrap <= s[0];
      crossover_auto_strap <= s[0];
      idle(16);
      rst_b <= 1'b1;
      idle(8);
      check("speed100", linkSpeed100, s[0]);
      check("autoneg", linkAutoNeg, s[0]);
      check("duplex", linkDuplexFull, 0);
      check("xover", crossoverAuto, s[0]);
    end
    for (int i = 0; i < 3; i++) begin
      reverseManual <= (i == 0);
      reverseDetected <= (i == 1);
      idle(6);
      check("swap", pairSwap, i < 2);
    end
    acc(7'h04, 1, 1, 16'h1111);
    acc(7'h05, 1, 1, 16'h2222);
    check("early tx", txCount, 0);
    check("armed", writesArmed, 0);
    acc(7'h00, 1, 0, 0);
    check("rx low", rdQ, 16'h4321);
    check("rd oe", rdOe, 1);
    acc(7'h01, 1, 0, 0);
    check("rx high", rdQ, 16'h8765);
    check("rx taken", rxCount, 1);
    check("idle oe", hostDataOe, 0);
    acc(7'h00, 0, 0, 0);
    check("unsel oe", rdOe, 0);
    acc(7'h04, 0, 1, 16'h3333);
    acc(7'h05, 0, 1, 16'h4444);
    check("unsel tx", txCount, 0);
    acc(7'h04, 1, 1, 16'hbeef);
    acc(7'h05, 1, 1, 16'hcafe);
    check("tx n", txCount, 1);
    check("tx word", txSeen, 32'hcafe_beef);
    acc(7'h12, 1, 1, 16'haaaa);
    acc(7'h13, 1, 1, 16'h5555);
    check("reg no tx", txCount, 1);
    acc(7'h12, 1, 0, 0);
    check("reg low", rdQ, 16'haaaa);
    acc(7'h13, 1, 0, 0);
    check("reg high", rdQ, 16'h5555);
    check("reg no pop", rxCount, 1);
    queueSelect <= 1'b1;
    acc(7'h70, 1, 1, 16'h0102);
    acc(7'h71, 1, 1, 16'h0304);
    check("queue word", txSeen, 32'h0304_0102);
    queueSelect <= 1'b0;
    bigEndian <= 1'b1;
    acc(7'h04, 1, 1, 16'h1234);
    acc(7'h05, 1, 1, 16'h5678);
    check("be word", txSeen, 32'h7856_3412);
    acc(7'h00, 1, 0, 0);
    check("be read", rdQ, 16'h2143);
    bigEndian <= 1'b0;
    lowPowerReq <= 1'b1;
    idle(6);
    lowPowerReq <= 1'b0;
    idle(6);
    check("sleep", lowPower, 1);
    acc(7'h04, 1, 1, 16'h5555);
    check("wake", lowPower, 0);
    check("rearm", writesArmed, 0);
    irqSources <= 8'h01;
    idle(10);
    check("irq on", irqOut, 1);
    check("irq oe", irqOe, 1);
    irqSources <= 8'h02;
    idle(10);
    check("irq mask", irqOut, 0);
    irqSources <= 8'h01;
    idle(20);
    check("irq gap", irqOut, 0);
    idle(80);
    check("irq again", irqOut, 1);
    irqOpenDrain <= 1'b1;
    irqActiveHigh <= 1'b0;
    idle(10);
    check("od low", irqOut, 0);
    check("od oe", irqOe, 1);
    irqSources <= 8'h00;
    idle(10);
    check("od off", irqOe, 0);
    complete_run();
  end
endmodule : shp_host_port_bench
`default_nettype wire
